/* core/uef_core.sv */
// uart channel enhanced control: halt bits, scratch pad, feature and enhanced features registers
`default_nettype none
module uef_core (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // timing strobes from the baud generator
  input wire logic bit_tick_i,
  input wire logic rx_tick16_i,
  // transmit fifo side
  input wire logic tx_fifo_valid_i,
  input wire logic [7:0] tx_fifo_data_i,
  output logic tx_fifo_pop_o,
  output logic tx_int_o,
  // receive fifo side
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_frame_err_o,
  // modem control and pins
  input wire logic modem_control_sel_dsr_i,
  input wire logic rts_manual_n_i,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic rx_i,
  input wire logic ir_rx_i,
  output logic tx_o,
  output logic rts_n_o,
  output logic ir_rx_active_o,
  // decoded flow control settings
  input wire logic [6:0] rx_trig_i,
  input wire logic [6:0] next_upper_trig_i,
  input wire logic [6:0] next_lower_trig_i,
  output logic [1:0] trig_table_o,
  output logic [6:0] rts_off_level_o,
  output logic [6:0] rts_on_level_o,
  output logic [1:0] sw_tx_sel_o,
  output logic [1:0] sw_rx_sel_o,
  output logic sw_tx_dual_o,
  output logic sw_rx_dual_o,
  output logic auto_rts_en_o,
  output logic special_char_en_o
);
  logic [7:0] spr_q, feature_control_q, efr_q, rdata_q;
  logic [5:0] msr_q;
  logic [1:0] cts_s_q, dsr_s_q, rx_s_q, ir_s_q;
  uef_pkg::uef_tx_state_t tx_st_q, tx_st_d;
  uef_pkg::uef_rx_state_t rx_st_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_cnt_q, turn_q;
  logic tx_q, rts_q, txint_q, ir_q;
  logic [3:0] rx_ph_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q, rx_data_q;
  logic rx_valid_q, rx_ferr_q;
  logic [6:0] off_q, on_q;
  wire flow_in, flow_stop;

  // decode of register accesses
  wire wr_msr = reg_wr_i && (reg_addr_i == uef_pkg::ADDR_MSR_WR);
  wire wr_spr = reg_wr_i && (reg_addr_i == uef_pkg::ADDR_SPR);
  wire wr_feature_control = reg_wr_i && (reg_addr_i == uef_pkg::ADDR_FEATURE_CONTROL);
  wire wr_efr = reg_wr_i && (reg_addr_i == uef_pkg::ADDR_EFR);
  wire enh_en = efr_q[uef_pkg::EFR_ENH_EN];
  wire tx_dis = msr_q[uef_pkg::MSR_TX_DIS - 2];
  wire rx_dis = msr_q[uef_pkg::MSR_RX_DIS - 2];
  wire [3:0] turn_dly = msr_q[5:2];
  wire auto485 = feature_control_q[uef_pkg::FEATURE_CONTROL_RS485];
  wire [1:0] tbl = feature_control_q[uef_pkg::FEATURE_CONTROL_TBL_LSB +: 2];
  wire [3:0] hys_sel = feature_control_q[uef_pkg::FEATURE_CONTROL_HYS_LSB +: 4];

  // status word: block state visible to software
  wire [7:0] status = {2'h0, rx_st_q != uef_pkg::RX_IDLE, tx_st_q == uef_pkg::TX_SHIFT,
    rts_q, flow_stop, rx_dis, tx_dis};
  wire [7:0] rd_mux =
    (reg_addr_i == uef_pkg::ADDR_SPR) ? spr_q :
    (reg_addr_i == uef_pkg::ADDR_FEATURE_CONTROL) ? feature_control_q :
    (reg_addr_i == uef_pkg::ADDR_EFR) ? efr_q :
    (reg_addr_i == uef_pkg::ADDR_STATUS) ? status : 8'h00;

  // register file; the modem status write bits are frozen unless enhanced enable is set
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spr_q <= uef_pkg::SPR_RESET;
      feature_control_q <= uef_pkg::FEATURE_CONTROL_RESET;
      efr_q <= uef_pkg::EFR_RESET;
      msr_q <= uef_pkg::MSR_CTL_RESET;
      rdata_q <= 8'h00;
    end else begin
      if (wr_spr) spr_q <= reg_wdata_i;
      if (wr_feature_control) feature_control_q <= reg_wdata_i;
      if (wr_efr) efr_q <= reg_wdata_i;
      if (wr_msr && enh_en) msr_q <= reg_wdata_i[7:2];
      rdata_q <= reg_rd_i ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata_o = rdata_q;

  // two-stage synchronisers for every pin input
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cts_s_q <= 2'h3;
      dsr_s_q <= 2'h3;
      rx_s_q <= 2'h3;
      ir_s_q <= 2'h0;
    end else begin
      cts_s_q <= {cts_s_q[0], cts_n_i};
      dsr_s_q <= {dsr_s_q[0], dsr_n_i};
      rx_s_q <= {rx_s_q[0], rx_i};
      ir_s_q <= {ir_s_q[0], ir_rx_i};
    end
  end

  // flow control input choice; high means the far end cannot take data
  assign flow_in = modem_control_sel_dsr_i ? dsr_s_q[1] : cts_s_q[1];
  assign flow_stop = efr_q[uef_pkg::EFR_AUTO_CTS] && flow_in;
  // a byte is only taken between characters, so a stop never cuts one short
  wire tx_between = (tx_st_q != uef_pkg::TX_SHIFT);
  wire tx_load = tx_between && tx_fifo_valid_i && !tx_dis && !flow_stop;
  wire tx_frame_end = (tx_st_q == uef_pkg::TX_SHIFT) && bit_tick_i && (tx_cnt_q == uef_pkg::TX_FRAME_BITS);
  assign tx_fifo_pop_o = tx_load;

  // next transmit state
  always_comb begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      uef_pkg::TX_IDLE: begin
        if (tx_load) tx_st_d = uef_pkg::TX_SHIFT;
      end
      uef_pkg::TX_SHIFT: begin
        if (tx_frame_end) tx_st_d = (turn_dly == 4'h0) ? uef_pkg::TX_IDLE : uef_pkg::TX_TURN;
      end
      uef_pkg::TX_TURN: begin
        if (tx_load) tx_st_d = uef_pkg::TX_SHIFT;
        else if (bit_tick_i && turn_q == 4'h1) tx_st_d = uef_pkg::TX_IDLE;
      end
      default: tx_st_d = uef_pkg::TX_IDLE;
    endcase
  end

  // transmit shifter; the line changes only on bit ticks, so the start bit always
  // follows the direction change by at least one clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_st_q <= uef_pkg::TX_IDLE;
      tx_sh_q <= 10'h3ff;
      tx_cnt_q <= 4'h0;
      turn_q <= 4'h0;
      tx_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      if (tx_load) begin
        tx_sh_q <= {1'b1, tx_fifo_data_i, 1'b0};
        tx_cnt_q <= 4'h0;
      end else if (tx_st_q == uef_pkg::TX_SHIFT && bit_tick_i) begin
        tx_q <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
      if (tx_frame_end) turn_q <= turn_dly;
      else if (tx_st_q == uef_pkg::TX_TURN && bit_tick_i) turn_q <= turn_q - 4'h1;
    end
  end
  assign tx_o = tx_q;

  // direction output and transmit interrupt condition
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rts_q <= 1'b1;
      txint_q <= 1'b1;
    end else begin
      rts_q <= auto485 ? (tx_st_d != uef_pkg::TX_IDLE) : rts_manual_n_i;
      txint_q <= auto485 ? (!tx_fifo_valid_i && tx_between) : !tx_fifo_valid_i;
    end
  end
  assign rts_n_o = rts_q;
  assign tx_int_o = txint_q;

  // infrared receive polarity
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) ir_q <= 1'b0;
    else ir_q <= ir_s_q[1] ^ feature_control_q[uef_pkg::FEATURE_CONTROL_IR_INV];
  end
  assign ir_rx_active_o = ir_q;

  // receiver; the disable bit only blocks a new start, fifo reads live outside and
  // are never gated here
  wire rx_line = rx_s_q[1];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_st_q <= uef_pkg::RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_ferr_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      case (rx_st_q)
        uef_pkg::RX_IDLE: begin
          rx_ph_q <= 4'h0;
          if (!rx_dis && !rx_line) rx_st_q <= uef_pkg::RX_START;
        end
        uef_pkg::RX_START: begin
          if (rx_tick16_i) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == uef_pkg::RX_MID_START) begin
              rx_ph_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_st_q <= rx_line ? uef_pkg::RX_IDLE : uef_pkg::RX_DATA;
            end
          end
        end
        uef_pkg::RX_DATA: begin
          if (rx_tick16_i) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == uef_pkg::RX_LAST_PHASE) begin
              rx_sh_q <= {rx_line, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == uef_pkg::RX_LAST_BIT) rx_st_q <= uef_pkg::RX_STOP;
            end
          end
        end
        uef_pkg::RX_STOP: begin
          // a character already started completes even if disabled meanwhile
          if (rx_tick16_i) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == uef_pkg::RX_LAST_PHASE) begin
              rx_data_q <= rx_sh_q;
              rx_ferr_q <= !rx_line;
              rx_valid_q <= 1'b1;
              rx_st_q <= uef_pkg::RX_IDLE;
            end
          end
        end
        default: rx_st_q <= uef_pkg::RX_IDLE;
      endcase
    end
  end
  assign rx_valid_o = rx_valid_q;
  assign rx_data_o = rx_data_q;
  assign rx_frame_err_o = rx_ferr_q;

  // hysteresis thresholds, clamped to the fifo range
  wire [5:0] hys = uef_pkg::HYST_TABLE[hys_sel];
  wire use_hys = (tbl == uef_pkg::TABLE_D) && (hys_sel != 4'h0);
  wire [7:0] up_sum = {1'b0, rx_trig_i} + {2'h0, hys};
  wire [7:0] up_lvl = (up_sum > uef_pkg::FIFO_MAX) ? uef_pkg::FIFO_MAX : up_sum;
  wire [6:0] low_lvl = (rx_trig_i > {1'b0, hys}) ? (rx_trig_i - {1'b0, hys}) : 7'h00;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      off_q <= 7'h00;
      on_q <= 7'h00;
    end else begin
      off_q <= use_hys ? up_lvl[6:0] : next_upper_trig_i;
      on_q <= use_hys ? low_lvl : next_lower_trig_i;
    end
  end
  assign rts_off_level_o = off_q;
  assign rts_on_level_o = on_q;

  // decoded settings; straight from the registers
  assign trig_table_o = tbl;
  assign sw_tx_sel_o = efr_q[uef_pkg::EFR_SWTX_LSB +: 2];
  assign sw_rx_sel_o = efr_q[uef_pkg::EFR_SWRX_LSB +: 2];
  assign sw_tx_dual_o = &efr_q[uef_pkg::EFR_SWTX_LSB +: 2];
  assign sw_rx_dual_o = &efr_q[uef_pkg::EFR_SWRX_LSB +: 2];
  assign auto_rts_en_o = efr_q[uef_pkg::EFR_AUTO_RTS];
  assign special_char_en_o = efr_q[uef_pkg::EFR_SPECIAL];

  // ---- checks ----
  // scratch pad: a write, a quiet cycle, then a read must return the written byte
  sequence s_spr_write;
    wr_spr ##1 !wr_spr ##1 (reg_rd_i && reg_addr_i == uef_pkg::ADDR_SPR);
  endsequence
  property p_spr_store;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_spr_write
      |=> reg_rdata_o == $past(reg_wdata_i, 3);
  endproperty
  a_spr_store: assert property (p_spr_store) else $error("scratch pad lost data");

  property p_tx_halt;
    @(posedge clk_i) disable iff (!reset_n_i) tx_dis |-> !tx_fifo_pop_o;
  endproperty
  a_tx_halt: assert property (p_tx_halt) else $error("byte taken while transmitter disabled");

  property p_tx_resume;
    @(posedge clk_i) disable iff (!reset_n_i)
      (tx_st_q == uef_pkg::TX_IDLE && tx_fifo_valid_i && !tx_dis && !flow_stop) |-> tx_fifo_pop_o;
  endproperty
  a_tx_resume: assert property (p_tx_resume) else $error("queued byte not taken");

  property p_msr_lock;
    @(posedge clk_i) disable iff (!reset_n_i) (wr_msr && !enh_en) |=> $stable(msr_q);
  endproperty
  a_msr_lock: assert property (p_msr_lock) else $error("locked control bits changed");

  property p_rx_halt;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rx_dis && rx_st_q == uef_pkg::RX_IDLE) |=> rx_st_q == uef_pkg::RX_IDLE;
  endproperty
  a_rx_halt: assert property (p_rx_halt) else $error("receiver started while disabled");

  sequence s_load_485;
    tx_load && auto485 && tx_st_q == uef_pkg::TX_IDLE;
  endsequence
  property p_rts_rise;
    @(posedge clk_i) disable iff (!reset_n_i) s_load_485 |=> rts_n_o && tx_o;
  endproperty
  a_rts_rise: assert property (p_rts_rise) else $error("direction late for start bit");

  property p_rts_fall;
    @(posedge clk_i) disable iff (!reset_n_i)
      (auto485 && tx_frame_end && turn_dly == 4'h0 && !tx_fifo_valid_i) |=> !rts_n_o;
  endproperty
  a_rts_fall: assert property (p_rts_fall) else $error("direction did not drop");

  property p_txint;
    @(posedge clk_i) disable iff (!reset_n_i)
      (auto485 && tx_st_q == uef_pkg::TX_SHIFT && $past(auto485)) |=> !tx_int_o;
  endproperty
  a_txint: assert property (p_txint) else $error("interrupt before shift empty");

  property p_flow;
    @(posedge clk_i) disable iff (!reset_n_i)
      (efr_q[uef_pkg::EFR_AUTO_CTS] && !modem_control_sel_dsr_i && cts_s_q[1]) |-> !tx_fifo_pop_o;
  endproperty
  a_flow: assert property (p_flow) else $error("sent while clear-to-send high");

  property p_hyst;
    @(posedge clk_i) disable iff (!reset_n_i)
      (tbl == uef_pkg::TABLE_D && hys_sel == 4'h1 && rx_trig_i == 7'h20) |=> rts_off_level_o == 7'h24;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis level wrong");

  property p_irpol;
    @(posedge clk_i) disable iff (!reset_n_i)
      $stable(feature_control_q) ##1 $stable(feature_control_q) |-> ir_rx_active_o == ($past(ir_s_q[1]) ^ feature_control_q[uef_pkg::FEATURE_CONTROL_IR_INV]);
  endproperty
  a_irpol: assert property (p_irpol) else $error("infrared polarity wrong");
endmodule
`default_nettype wire

/* core/uef_pkg.sv */
// package of constants and types for the uart enhanced feature control block
`default_nettype none
package uef_pkg;
  // register indices on the local register port
  localparam logic [3:0] ADDR_MSR_WR = 4'h6;
  localparam logic [3:0] ADDR_SPR = 4'h7;
  localparam logic [3:0] ADDR_FEATURE_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_EFR = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'ha;
  // values after reset
  localparam logic [7:0] SPR_RESET = 8'hff;
  localparam logic [7:0] FEATURE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] EFR_RESET = 8'h00;
  localparam logic [5:0] MSR_CTL_RESET = 6'h00;
  // field positions of the modem status write register
  localparam int MSR_TX_DIS = 3;
  localparam int MSR_RX_DIS = 2;
  localparam int MSR_DLY_LSB = 4;
  // field positions of the feature control register
  localparam int FEATURE_CONTROL_TBL_LSB = 6;
  localparam int FEATURE_CONTROL_RS485 = 5;
  localparam int FEATURE_CONTROL_IR_INV = 4;
  localparam int FEATURE_CONTROL_HYS_LSB = 0;
  localparam logic [1:0] TABLE_D = 2'h3;
  // field positions of the enhanced features register
  localparam int EFR_AUTO_CTS = 7;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_SPECIAL = 5;
  localparam int EFR_ENH_EN = 4;
  localparam int EFR_SWTX_LSB = 2;
  localparam int EFR_SWRX_LSB = 0;
  // fifo level limit and frame shape
  localparam logic [7:0] FIFO_MAX = 8'h40;
  localparam logic [3:0] TX_FRAME_BITS = 4'ha;
  localparam logic [3:0] RX_MID_START = 4'h7;
  localparam logic [3:0] RX_LAST_PHASE = 4'hf;
  localparam logic [2:0] RX_LAST_BIT = 3'h7;
  // hysteresis in characters, indexed by the four-bit select field
  localparam logic [5:0] HYST_TABLE [16] = '{
    6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
    6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24
  };
  typedef enum {TX_IDLE, TX_SHIFT, TX_TURN} uef_tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} uef_rx_state_t;
endpackage
`default_nettype wire

/* tb/tb_uart_enhanced_feature_control.sv */
// self-checking bench for the uart enhanced feature control block
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_uart_enhanced_feature_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, tx_data = 8'h00, rdat, rx_data, got;
  logic wr = 1'b0, rd = 1'b0, bit_tick = 1'b0, rx_t16 = 1'b0, tx_valid = 1'b0, sel_dsr = 1'b0;
  logic cts_n = 1'b0, dsr_n = 1'b0, ir_rx = 1'b0, rts_man_n = 1'b0;
  logic rx_line, pop, tx_int, rx_valid, ferr, tx_line, rts_n, ir_act, swtd, swrd, arts, spc;
  logic [6:0] trig = 7'h20, up = 7'h28, dn = 7'h18, off_l, on_l;
  logic [1:0] tbl, swt, swr;
  logic [4:0] div = 5'h00;
  logic [7:0] q [$];
  int num_errors = 0, samples_checked = 0, frames, rx_cnt = 0;
  int hys [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};

  always #50 clk_i = ~clk_i;

  // bit time of 32 clocks; transmit fifo stand-in hands its head byte over on pop
  always @(posedge clk_i) begin
    div <= div + 5'h01;
    rx_t16 <= div[0];
    bit_tick <= (div == 5'h1f);
    if (pop === 1'b1 && q.size() > 0) void'(q.pop_front());
    tx_valid <= (q.size() != 0);
    tx_data <= (q.size() != 0) ? q[0] : 8'h00;
    if (rx_valid === 1'b1) rx_cnt++;
  end

  uef_core i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdat), .bit_tick_i(bit_tick), .rx_tick16_i(rx_t16),
    .tx_fifo_valid_i(tx_valid), .tx_fifo_data_i(tx_data), .tx_fifo_pop_o(pop), .tx_int_o(tx_int),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_frame_err_o(ferr), .modem_control_sel_dsr_i(sel_dsr),
    .rts_manual_n_i(rts_man_n), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .rx_i(rx_line), .ir_rx_i(ir_rx),
    .tx_o(tx_line), .rts_n_o(rts_n), .ir_rx_active_o(ir_act), .rx_trig_i(trig), .next_upper_trig_i(up),
    .next_lower_trig_i(dn), .trig_table_o(tbl), .rts_off_level_o(off_l), .rts_on_level_o(on_l),
    .sw_tx_sel_o(swt), .sw_rx_sel_o(swr), .sw_tx_dual_o(swtd), .sw_rx_dual_o(swrd),
    .auto_rts_en_o(arts), .special_char_en_o(spc)
  );

  uef_line_peer i_peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line), .got_o(got), .frames_o(frames));

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // register port: one-cycle strobes, read data taken in the cycle after the strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    @(posedge clk_i);
    `CHK(rdat, e)
  endtask

  // bounded waits; running out counts as a mismatch and ends the run
  task automatic wait_lvl(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge clk_i);
    if (s !== v) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; i < 1000 && frames < n; i++) @(posedge clk_i);
    if (frames < n) begin
      num_errors++;
      close_out();
    end
  endtask

  initial begin
    #9000000;
    num_errors++;
    close_out();
  end

  initial begin
    int eo;
    int en;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // reset values, unmapped and write-only reads, scratch pad storage
    chk_reg(uef_pkg::ADDR_SPR, 8'hff);
    chk_reg(uef_pkg::ADDR_FEATURE_CONTROL, 8'h00);
    chk_reg(uef_pkg::ADDR_EFR, 8'h00);
    chk_reg(4'hf, 8'h00);
    chk_reg(uef_pkg::ADDR_MSR_WR, 8'h00);
    wr_reg(uef_pkg::ADDR_SPR, 8'h5a);
    chk_reg(uef_pkg::ADDR_SPR, 8'h5a);
    // halt bits refused until the enhanced enable is set; reserved bits inert
    wr_reg(uef_pkg::ADDR_MSR_WR, 8'h0c);
    chk_reg(uef_pkg::ADDR_STATUS, 8'h00);
    wr_reg(uef_pkg::ADDR_EFR, 8'h10);
    wr_reg(uef_pkg::ADDR_MSR_WR, 8'h0b);
    chk_reg(uef_pkg::ADDR_STATUS, 8'h01);
    q.push_back(8'ha5);
    repeat (400) @(posedge clk_i);
    `CHK(frames, 0)
    wr_reg(uef_pkg::ADDR_MSR_WR, 8'h00);
    wait_frames(1);
    `CHK(got, 8'ha5)
    $display("test registers and halt done");
    // auto flow control on the selected input, current character always finishes
    // pins go through two flops, so they are raised before the byte or the select can race them
    cts_n <= 1'b1;
    wr_reg(uef_pkg::ADDR_EFR, 8'h90);
    q.push_back(8'h11);
    repeat (400) @(posedge clk_i);
    `CHK(frames, 1)
    dsr_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    sel_dsr <= 1'b1;
    cts_n <= 1'b0;
    repeat (400) @(posedge clk_i);
    `CHK(frames, 1)
    dsr_n <= 1'b0;
    wait_frames(2);
    `CHK(got, 8'h11)
    q.push_back(8'h22);
    q.push_back(8'h33);
    wait_lvl(pop, 1'b1, 50);
    dsr_n <= 1'b1;
    wait_frames(3);
    `CHK(got, 8'h22)
    repeat (400) @(posedge clk_i);
    `CHK(frames, 3)
    dsr_n <= 1'b0;
    wait_frames(4);
    `CHK(got, 8'h33)
    repeat (40) @(posedge clk_i);
    $display("test flow control done");
    // direction output and transmit interrupt with and without auto rs485
    wr_reg(uef_pkg::ADDR_EFR, 8'h10);
    wr_reg(uef_pkg::ADDR_FEATURE_CONTROL, 8'h20);
    @(posedge clk_i);
    `CHK(rts_n, 1'b0)
    q.push_back(8'h44);
    wait_lvl(pop, 1'b1, 50);
    @(posedge clk_i);
    `CHK({rts_n, tx_line}, 2'h3)
    repeat (2) @(posedge clk_i);
    `CHK(tx_int, 1'b0)
    wait_frames(5);
    `CHK(rts_n, 1'b1)
    wait_lvl(rts_n, 1'b0, 40);
    @(posedge clk_i);
    `CHK({got, tx_int}, 9'h089)
    wr_reg(uef_pkg::ADDR_FEATURE_CONTROL, 8'h00);
    rts_man_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(rts_n, 1'b1)
    rts_man_n <= 1'b0;
    q.push_back(8'h55);
    wait_lvl(pop, 1'b1, 50);
    repeat (3) @(posedge clk_i);
    `CHK(tx_int, 1'b1)
    wait_frames(6);
    $display("test direction control done");
    // infrared polarity, trigger tables and hysteresis decode
    ir_rx <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK(ir_act, 1'b1)
    wr_reg(uef_pkg::ADDR_FEATURE_CONTROL, 8'h10);
    repeat (3) @(posedge clk_i);
    `CHK(ir_act, 1'b0)
    up <= 7'h3c;
    dn <= 7'h10;
    for (int t = 0; t < 3; t++) begin
      wr_reg(uef_pkg::ADDR_FEATURE_CONTROL, {t[1:0], 6'h05});
      repeat (2) @(posedge clk_i);
      `CHK({tbl, off_l, on_l}, {t[1:0], up, dn})
    end
    for (int h = 0; h < 16; h++) begin
      wr_reg(uef_pkg::ADDR_FEATURE_CONTROL, {4'hc, h[3:0]});
      eo = (h == 0) ? up : (32 + hys[h] > 64) ? 64 : 32 + hys[h];
      en = (h == 0) ? dn : (hys[h] > 32) ? 0 : 32 - hys[h];
      repeat (2) @(posedge clk_i);
      `CHK({tbl, off_l, on_l}, {2'h3, eo[6:0], en[6:0]})
    end
    // another receive trigger: 56 plus 32 clamps at 64, 56 minus 32 is 24
    trig <= 7'h38;
    wr_reg(uef_pkg::ADDR_FEATURE_CONTROL, 8'hc7);
    repeat (2) @(posedge clk_i);
    `CHK({off_l, on_l}, {7'h40, 7'h18})
    // software flow control selects, cleared before every new setting
    for (int v = 0; v < 16; v++) begin
      wr_reg(uef_pkg::ADDR_EFR, 8'h10);
      wr_reg(uef_pkg::ADDR_EFR, {4'h1, v[3:0]});
      @(posedge clk_i);
      `CHK({swt, swr, swtd, swrd}, {v[3:0], &v[3:2], &v[1:0]})
    end
    wr_reg(uef_pkg::ADDR_EFR, 8'h70);
    @(posedge clk_i);
    `CHK({arts, spc, swt, swr}, 6'h30)
    $display("test feature decode done");
    // receiver halt in mid character, then re-enable with the line idle
    fork
      i_peer.send(8'h3c);
    join_none
    wait_lvl(rx_valid, 1'b1, 400);
    `CHK(rx_data, 8'h3c)
    repeat (40) @(posedge clk_i);
    fork
      i_peer.send(8'h96);
    join_none
    repeat (100) @(posedge clk_i);
    wr_reg(uef_pkg::ADDR_MSR_WR, 8'h04);
    wait_lvl(rx_valid, 1'b1, 400);
    `CHK(rx_data, 8'h96)
    repeat (40) @(posedge clk_i);
    i_peer.send(8'h0f);
    repeat (40) @(posedge clk_i);
    `CHK(rx_cnt, 2)
    `CHK(rx_data, 8'h96)
    wr_reg(uef_pkg::ADDR_MSR_WR, 8'h00);
    fork
      i_peer.send(8'he1);
    join_none
    wait_lvl(rx_valid, 1'b1, 400);
    `CHK({ferr, rx_data}, 9'h0e1)
    // clearing the enhanced enable latches the halt bits
    repeat (40) @(posedge clk_i);
    wr_reg(uef_pkg::ADDR_MSR_WR, 8'h08);
    wr_reg(uef_pkg::ADDR_EFR, 8'h00);
    wr_reg(uef_pkg::ADDR_MSR_WR, 8'h04);
    chk_reg(uef_pkg::ADDR_STATUS, 8'h01);
    $display("test receiver and latch done");
    close_out();
  end
endmodule
`undef CHK
`default_nettype wire

/* tb/uef_line_peer.sv */
// serial line peer: decodes frames from the block and sends frames into it
`default_nettype none
module uef_line_peer (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o,
  output logic [7:0] got_o,
  output int frames_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CLKS = 32;
  // the line idles high, as through the receive pull-up
  initial begin
    line_o = 1'b1;
    got_o = 8'h00;
    frames_o = 0;
  end
  // sample each bit in its middle, lsb first; a frame counts only with a high stop bit
  always @(negedge line_i) begin
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      got_o[i] = line_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    if (line_i) frames_o++;
  end
  // start bit, eight data bits lsb first, stop bit; line left idle high after
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire
